//--- rtl/pin_mux_defines.vh
// Register map, field positions, reset values and timing for the pin mux
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH
`define OFF_SEL 8'h00
`define OFF_CTRL 8'h04
`define OFF_STATUS 8'h08
`define OFF_BASE 8'h0c
`define OFF_HOSTWR 8'h10
`define OFF_HOSTRD 8'h14
`define SEL_ACK_HI 5
`define SEL_ACK_LO 4
`define SEL_REQ_HI 7
`define SEL_REQ_LO 6
`define CTRL_EPP 0
`define CTRL_IRQ8_HIGH 1
`define CTRL_WDT_ALT 2
`define CTRL_LED_ALT 3
`define ST_TC_SEEN 0
`define ST_ACK_PIN 1
`define ST_REQ_PIN 2
`define ST_HOST_WR 3
`define SEL_RST 8'h00
`define CTRL_RST 4'h0
`define BASE_RST 16'h0300
`define HOSTRD_RST 8'h00
`define FN_DMA 2'h0
`define FN_GPIO 2'h1
`define FN_KBD 2'h2
`define FN_UART 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_NS 4
`define HOLD_NS 100
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- rtl/host_side_pin_function_mux.v
// Host-side shared pin function mux with ISA slave port and AXI4-Lite regs
//
// Notes on behaviour
// - Select 00 on bits 5:4: acknowledge pin is DMA channel 0 acknowledge.
// - Select 01: acknowledge pin is GPIO port 1 bit 6 or watchdog out.
// - Select 10: acknowledge pin is bidirectional keyboard port line five.
// - Select 11: acknowledge pin drives third UART request-to-send.
// - Select 00 on bits 7:6: request pin drives DMA channel 0 request.
// - Select 01: request pin is GPIO port 1 bit 7 or power LED out.
// - Select 10: request pin is bidirectional keyboard port line four.
// - Select 11: request pin drives third UART data-terminal-ready.
// - In EPP mode, open-drain channel ready stretches the host cycle.
// - Master reset is active high and resets the device while high.
// - Terminal count ends the transfer on the acknowledged channel.
// - IRQ8 defaults active low, active high selectable.
// - Full 16-bit host address decode, 8-bit bidirectional data.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defines.vh"
module host_side_pin_function_mux (
   input wire ref_clk,
   input wire resetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   input wire [15:0] hostAddr,
   input wire [7:0] hostDataIn,
   output reg [7:0] hostDataOut,
   output wire hostDataOe,
   input wire iorN,
   input wire iowN,
   input wire aen,
   output wire chrdyOut,
   output wire chrdyOe,
   input wire masterResetIn,
   input wire tcIn,
   input wire ackPinIn,
   output reg ackPinOut,
   output reg ackPinOe,
   input wire reqPinIn,
   output reg reqPinOut,
   output reg reqPinOe,
   input wire rtcIrqIn,
   output reg rtcIrqPin,
   output reg dmaAck0N,
   input wire dmaReq0,
   output reg tcDone,
   input wire gpio1LineSixOut,
   input wire gpio1LineSixOe,
   output reg gpio1LineSixIn,
   input wire watchdogTimeoutOut,
   input wire gpio1LineSevenOut,
   input wire gpio1LineSevenOe,
   output reg gpio1LineSevenIn,
   input wire powerLedOut,
   input wire keyboardPortLineFiveOut,
   input wire keyboardPortLineFiveOe,
   output reg keyboardPortLineFiveIn,
   input wire keyboardPortLineFourOut,
   input wire keyboardPortLineFourOe,
   output reg keyboardPortLineFourIn,
   input wire thirdUartRtsOut,
   input wire thirdUartDtrOut
);
   localparam ST_IDLE = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_ACT = 3'b100;
   localparam [31:0] HOLD_FULL = `HOLD_CYC - 1;
   localparam [7:0] HOLD_LAST = HOLD_FULL[7:0];

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg [30:0] sync1;
   reg [30:0] sync2;
   wire [15:0] sAddr = sync2[30:15];
   wire [7:0] sData = sync2[14:7];
   wire sIorN = sync2[6];
   wire sIowN = sync2[5];
   wire sAen = sync2[4];
   wire sMr = sync2[3];
   wire sTc = sync2[2];
   wire sAck = sync2[1];
   wire sReq = sync2[0];

   always @(posedge ref_clk) begin
      if (!resetn) begin
         sync1 <= {16'h0000, 8'h00, 7'h63};
         sync2 <= {16'h0000, 8'h00, 7'h63};
      end else begin
         sync1 <= {hostAddr, hostDataIn, iorN, iowN, aen,
                   masterResetIn, tcIn, ackPinIn, reqPinIn};
         sync2 <= sync1;
      end
   end

   wire rst = !resetn | sMr;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] sel;
   reg [3:0] ctrl;
   reg [15:0] baseAddr;
   reg [7:0] hostWr;
   reg [7:0] hostRd;
   reg tcSeen;
   reg hostWrSeen;
   reg [7:0] awHeld;
   reg awHave;
   reg [31:0] wHeld;
   reg [3:0] sHeld;
   reg wHave;

   wire [1:0] ackFn = sel[`SEL_ACK_HI:`SEL_ACK_LO];
   wire [1:0] reqFn = sel[`SEL_REQ_HI:`SEL_REQ_LO];

   assign awready = !awHave & !bvalid;
   assign wready = !wHave & !bvalid;
   assign arready = !rvalid;

   wire awTake = awvalid & awready;
   wire wTake = wvalid & wready;
   wire [7:0] wAddr = awHave ? awHeld : awaddr;
   wire [31:0] wDat = wHave ? wHeld : wdata;
   wire [3:0] wStb = wHave ? sHeld : wstrb;
   wire doWrite = (awHave | awTake) & (wHave | wTake);
   wire wrStatus = doWrite & (wAddr == `OFF_STATUS) & wStb[0];
   wire wMapped = (wAddr == `OFF_SEL) | (wAddr == `OFF_CTRL) |
                  (wAddr == `OFF_STATUS) | (wAddr == `OFF_BASE) |
                  (wAddr == `OFF_HOSTRD);

   // ------------------------------------------------------------
   // Host I/O cycle
   // ------------------------------------------------------------
   reg [2:0] state;
   reg [7:0] holdCnt;
   reg isRead;
   // full 16-bit match, address enable gates strobes
   wire hit = (sAddr == baseAddr) & !sAen & (!sIorN | !sIowN);
   wire hostWrEv = (state == ST_IDLE) & hit & sIorN;

   always @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         holdCnt <= 8'h00;
         isRead <= 1'b0;
         hostWr <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (hit) begin
                  isRead <= !sIorN;
                  if (sIorN)
                     hostWr <= sData;
                  holdCnt <= HOLD_LAST;
                  if (ctrl[`CTRL_EPP])
                     state <= ST_HOLD;
                  else
                     state <= ST_ACT;
               end
            end
            ST_HOLD: begin
               if (holdCnt == 8'h00)
                  state <= ST_ACT;
               else
                  holdCnt <= holdCnt - 8'h01;
            end
            ST_ACT: begin
               if (sIorN & sIowN)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Channel ready only ever pulls low; the bus pull-up releases it
   assign chrdyOut = 1'b0;
   assign chrdyOe = (state == ST_HOLD);
   // data bus driven only during our read
   assign hostDataOe = isRead & (state != ST_IDLE);

   // ------------------------------------------------------------
   // Terminal count
   // ------------------------------------------------------------
   reg reqBlock;
   reg tcEndD;
   wire tcEnd = sTc & (ackFn == `FN_DMA) & !sAck;

   always @(posedge ref_clk) begin
      if (rst) begin
         reqBlock <= 1'b0;
         tcEndD <= 1'b0;
         tcDone <= 1'b0;
      end else begin
         tcEndD <= tcEnd;
         tcDone <= tcEnd & !tcEndD;
         if (tcEnd)
            reqBlock <= 1'b1;
         else if (!dmaReq0)
            reqBlock <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         sel <= `SEL_RST;
         ctrl <= `CTRL_RST;
         baseAddr <= `BASE_RST;
         hostRd <= `HOSTRD_RST;
         hostDataOut <= `HOSTRD_RST;
         tcSeen <= 1'b0;
         hostWrSeen <= 1'b0;
         awHave <= 1'b0;
         awHeld <= 8'h00;
         wHave <= 1'b0;
         wHeld <= 32'h00000000;
         sHeld <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `RESP_OKAY;
         rdata <= 32'h00000000;
      end else begin
         hostDataOut <= hostRd;
         // Set wins over a simultaneous clear
         tcSeen <= (tcEnd & !tcEndD) |
                   (tcSeen & !(wrStatus & wDat[`ST_TC_SEEN]));
         hostWrSeen <= hostWrEv |
                       (hostWrSeen & !(wrStatus & wDat[`ST_HOST_WR]));
         if (doWrite) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wMapped ? `RESP_OKAY : `RESP_SLVERR;
            if (wStb[0]) begin
               case (wAddr)
                  // new select drives pins next cycle
                  `OFF_SEL: sel <= wDat[7:0];
                  `OFF_CTRL: ctrl <= wDat[3:0];
                  `OFF_BASE: baseAddr[7:0] <= wDat[7:0];
                  `OFF_HOSTRD: hostRd <= wDat[7:0];
                  default: ;
               endcase
            end
            if (wStb[1] & (wAddr == `OFF_BASE))
               baseAddr[15:8] <= wDat[15:8];
         end else begin
            if (awTake) begin
               awHave <= 1'b1;
               awHeld <= awaddr;
            end
            if (wTake) begin
               wHave <= 1'b1;
               wHeld <= wdata;
               sHeld <= wstrb;
            end
         end
         if (bvalid & bready)
            bvalid <= 1'b0;
         if (arvalid & arready) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (araddr)
               `OFF_SEL: rdata <= {24'h000000, sel};
               `OFF_CTRL: rdata <= {28'h0000000, ctrl};
               `OFF_STATUS:
                  rdata <= {28'h0000000, hostWrSeen, sReq, sAck, tcSeen};
               `OFF_BASE: rdata <= {16'h0000, baseAddr};
               `OFF_HOSTWR: rdata <= {24'h000000, hostWr};
               `OFF_HOSTRD: rdata <= {24'h000000, hostRd};
               default: begin
                  rdata <= 32'h00000000;
                  rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (rvalid & rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // IRQ8 polarity
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst)
         rtcIrqPin <= 1'b1;
      else
         rtcIrqPin <= ctrl[`CTRL_IRQ8_HIGH] ? rtcIrqIn : !rtcIrqIn;
   end

   // ------------------------------------------------------------
   // Shared pin muxes
   // ------------------------------------------------------------
   always @* begin
      ackPinOut = 1'b0;
      ackPinOe = 1'b0;
      dmaAck0N = 1'b1;
      gpio1LineSixIn = 1'b0;
      keyboardPortLineFiveIn = 1'b1;
      case (ackFn)
         `FN_DMA: dmaAck0N = sAck;
         `FN_GPIO: begin
            gpio1LineSixIn = sAck;
            if (ctrl[`CTRL_WDT_ALT]) begin
               ackPinOut = watchdogTimeoutOut;
               ackPinOe = 1'b1;
            end else begin
               ackPinOut = gpio1LineSixOut;
               ackPinOe = gpio1LineSixOe;
            end
         end
         `FN_KBD: begin
            keyboardPortLineFiveIn = sAck;
            ackPinOut = keyboardPortLineFiveOut;
            ackPinOe = keyboardPortLineFiveOe;
         end
         default: begin
            ackPinOut = thirdUartRtsOut;
            ackPinOe = 1'b1;
         end
      endcase
   end

   always @* begin
      reqPinOut = 1'b0;
      reqPinOe = 1'b0;
      gpio1LineSevenIn = 1'b0;
      keyboardPortLineFourIn = 1'b1;
      case (reqFn)
         `FN_DMA: begin
            reqPinOut = dmaReq0 & !reqBlock;
            reqPinOe = 1'b1;
         end
         // GPIO bit 7 or power LED
         `FN_GPIO: begin
            gpio1LineSevenIn = sReq;
            if (ctrl[`CTRL_LED_ALT]) begin
               reqPinOut = powerLedOut;
               reqPinOe = 1'b1;
            end else begin
               reqPinOut = gpio1LineSevenOut;
               reqPinOe = gpio1LineSevenOe;
            end
         end
         `FN_KBD: begin
            keyboardPortLineFourIn = sReq;
            reqPinOut = keyboardPortLineFourOut;
            reqPinOe = keyboardPortLineFourOe;
         end
         default: begin
            reqPinOut = thirdUartDtrOut;
            reqPinOe = 1'b1;
         end
      endcase
   end
endmodule
`default_nettype wire

//--- test/pin_mux_assertions.sv
// Port-level assertions for the host side pin function mux
`timescale 1ns/1ps
`default_nettype none
module pin_mux_assertions (
   input wire ref_clk,
   input wire resetn,
   input wire masterResetIn,
   input wire bvalid,
   input wire bready,
   input wire [1:0] bresp,
   input wire rvalid,
   input wire rready,
   input wire [31:0] rdata,
   input wire chrdyOut,
   input wire chrdyOe,
   input wire dmaAck0N,
   input wire ackPinOe,
   input wire tcDone,
   input wire reqPinOut
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Stretch holds ready low for the whole hold count, then lets go
   sequence s_hold8;
      chrdyOe [*8];
   endsequence
   sequence s_stretch;
      s_hold8 ##1 s_hold8 ##1 s_hold8 ##1 chrdyOe ##1 !chrdyOe;
   endsequence
   property p_ack_input; !dmaAck0N |-> !ackPinOe; endproperty
   property p_chrdy_od; chrdyOe |-> !chrdyOut; endproperty
   property p_chrdy_len; $rose(chrdyOe) |-> s_stretch; endproperty
   property p_mr;
      masterResetIn [*4] |-> !bvalid && !rvalid && !chrdyOe;
   endproperty
   property p_tc_pulse; tcDone |=> !tcDone; endproperty
   property p_tc_req; tcDone |=> !reqPinOut; endproperty
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_ack_input: assert property (p_ack_input)
      else $error("dma ack low while pin driven");
   a_chrdy_od: assert property (p_chrdy_od)
      else $error("channel ready driven high");
   a_chrdy_len: assert property (p_chrdy_len)
      else $error("channel ready stretch length wrong");
   a_mr: assert property (p_mr)
      else $error("master reset did not clear state");
   a_tc_pulse: assert property (p_tc_pulse)
      else $error("tc done longer than one cycle");
   a_tc_req: assert property (p_tc_req)
      else $error("request not dropped after tc");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
endmodule
bind host_side_pin_function_mux pin_mux_assertions chk_u (.*);
`default_nettype wire

//--- test/isa_host_model.sv
// ISA chipset and DMA controller model facing the pin mux
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
   input wire logic ref_clk,
   input wire logic chrdyOe,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   output logic [15:0] hostAddr = 16'h0000,
   output logic [7:0] hostDataIn = 8'h00,
   output logic iorN = 1'b1,
   output logic iowN = 1'b1,
   output logic aen = 1'b0,
   output logic tcIn = 1'b0,
   output logic masterResetIn = 1'b0
);
   int stretch = 0;
   always @(posedge ref_clk) if (chrdyOe) stretch <= stretch + 1;
   task cyc(input logic wr, input logic [15:0] a, input logic [7:0] d,
      input logic en, output logic [7:0] q);
      int n;
      begin
         @(posedge ref_clk);
         hostAddr <= a;
         hostDataIn <= d;
         aen <= en;
         stretch = 0;
         @(posedge ref_clk);
         if (wr) iowN <= 1'b0;
         else iorN <= 1'b0;
         n = 0;
         do begin
            @(negedge ref_clk);
            n++;
         end while ((n < 6 || chrdyOe) && n < 80);
         q = hostDataOe ? hostDataOut : ~d;
         @(posedge ref_clk);
         iorN <= 1'b1;
         iowN <= 1'b1;
         aen <= 1'b0;
         // Released bus shows no stale value
         hostDataIn <= ~d;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   task tc;
      @(posedge ref_clk) tcIn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      tcIn <= 1'b0;
   endtask
   task mreset;
      @(posedge ref_clk) masterResetIn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      masterResetIn <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- test/test_host_side_pin_function_mux.sv
// Self-checking bench for the host side pin function mux
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defines.vh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
   mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_host_side_pin_function_mux;
   logic ref_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, ackDrv = 1, reqDrv = 0, dmaReq0 = 1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, hq;
   logic [31:0] wdata = 32'h0, q;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] r;
   logic hA, hW, hR, dn, rtcIrqIn = 0, watchdogTimeoutOut = 0;
   logic gpio1LineSixOut = 1, gpio1LineSixOe = 1, powerLedOut = 1;
   logic gpio1LineSevenOut = 0, gpio1LineSevenOe = 1, thirdUartRtsOut = 1;
   logic keyboardPortLineFiveOut = 0, keyboardPortLineFiveOe = 1;
   logic keyboardPortLineFourOut = 1, keyboardPortLineFourOe = 0;
   logic thirdUartDtrOut = 0;
   wire awready, wready, bvalid, arready, rvalid, hostDataOe, chrdyOut;
   wire chrdyOe, ackPinOut, ackPinOe, reqPinOut, reqPinOe, rtcIrqPin;
   wire dmaAck0N, tcDone, gpio1LineSixIn, gpio1LineSevenIn;
   wire keyboardPortLineFiveIn, keyboardPortLineFourIn;
   wire iorN, iowN, aen, tcIn, masterResetIn;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] hostDataOut, hostDataIn;
   wire [15:0] hostAddr;
   wire ackPinIn = ackPinOe ? ackPinOut : ackDrv;
   wire reqPinIn = reqPinOe ? reqPinOut : reqDrv;
   int mismatches = 0, total_checks = 0;
   host_side_pin_function_mux dut_u (.*);
   isa_host_model host_u (.*);
   always #2 ref_clk = ~ref_clk;
   task results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task axi(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge ref_clk);
         awaddr <= a;
         araddr <= a;
         wdata <= d;
         awvalid <= w;
         wvalid <= w;
         bready <= w;
         arvalid <= !w;
         rready <= !w;
         n = 0;
         do begin
            @(negedge ref_clk);
            n++;
            hA = awvalid & awready;
            hW = wvalid & wready;
            hR = arvalid & arready;
            dn = w ? bvalid : rvalid;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge ref_clk);
            if (hA) awvalid <= 1'b0;
            if (hW) wvalid <= 1'b0;
            if (hR) arvalid <= 1'b0;
         end while (!dn);
         bready <= 1'b0;
         rready <= 1'b0;
      end
   endtask
   task t_regs;
      axi(0, `OFF_SEL, 0);
      `CHK("sel reset", 32'h0, q)
      axi(0, `OFF_BASE, 0);
      `CHK("base reset", 32'h0300, q)
      axi(0, 8'h40, 0);
      `CHK("unmapped resp", `RESP_SLVERR, r)
      axi(1, `OFF_HOSTWR, 32'h11);
      `CHK("ro resp", `RESP_SLVERR, r)
      `CHK("req oe", 1'b1, reqPinOe)
      $display("t_regs done");
   endtask
   task t_mux;
      for (int f = 0; f < 4; f++) begin
         ackDrv <= 1'b0;
         axi(1, `OFF_SEL, {24'h0, f[1:0], f[1:0], 4'h0});
         repeat (4) @(posedge ref_clk);
         `CHK("ack oe", f != 0, ackPinOe)
         if (f != 0) `CHK("ack out", 4'b1010 >> f & 1, ackPinOut)
         `CHK("dma ack", f != 0, dmaAck0N)
         `CHK("gpio6 in", f == 1, gpio1LineSixIn)
         `CHK("kbd5 in", f != 2, keyboardPortLineFiveIn)
         `CHK("req oe", f != 2, reqPinOe)
         if (f != 2) `CHK("req out", 4'b0001 >> f & 1, reqPinOut)
         `CHK("kbd4 in", f != 2, keyboardPortLineFourIn)
      end
      axi(1, `OFF_SEL, 32'h50);
      axi(1, `OFF_CTRL, 32'hc);
      repeat (2) @(posedge ref_clk);
      `CHK("wdt out", 1'b0, ackPinOut)
      `CHK("led out", 1'b1, reqPinOut)
      `CHK("gpio7 in", 1'b1, gpio1LineSevenIn)
      axi(1, `OFF_CTRL, 32'h0);
      axi(1, `OFF_SEL, 32'h0);
      $display("t_mux done");
   endtask
   task t_tc;
      int n;
      begin
         n = 0;
         fork
            host_u.tc();
            while (!tcDone && n < 20) begin
               @(negedge ref_clk);
               n++;
            end
         join
         `CHK("tc pulse", 1'b1, n < 20)
         `CHK("req held", 1'b0, reqPinOut)
         axi(0, `OFF_STATUS, 0);
         `CHK("tc seen", 1'b1, q[`ST_TC_SEEN])
         axi(1, `OFF_STATUS, 32'h1);
         axi(0, `OFF_STATUS, 0);
         `CHK("tc clear", 1'b0, q[`ST_TC_SEEN])
         $display("t_tc done");
      end
   endtask
   task t_isa;
      host_u.cyc(1, 16'h0300, 8'ha5, 0, hq);
      host_u.cyc(1, 16'h0300, 8'h33, 1, hq);
      host_u.cyc(1, 16'h1300, 8'h44, 0, hq);
      axi(0, `OFF_HOSTWR, 0);
      `CHK("host write", 32'ha5, q)
      axi(1, `OFF_HOSTRD, 32'h5a);
      host_u.cyc(0, 16'h0300, 8'h00, 0, hq);
      `CHK("host read", 8'h5a, hq)
      axi(1, `OFF_CTRL, 32'h1);
      host_u.cyc(1, 16'h0300, 8'h77, 0, hq);
      `CHK("epp stretch", `HOLD_CYC, host_u.stretch)
      axi(1, `OFF_CTRL, 32'h0);
      $display("t_isa done");
   endtask
   task t_irq;
      rtcIrqIn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("irq low", 1'b0, rtcIrqPin)
      axi(1, `OFF_CTRL, 32'h2);
      repeat (3) @(posedge ref_clk);
      `CHK("irq high", 1'b1, rtcIrqPin)
      rtcIrqIn <= 1'b0;
      axi(1, `OFF_SEL, 32'hf0);
      host_u.mreset();
      axi(0, `OFF_SEL, 0);
      `CHK("mr clears", 32'h0, q)
      $display("t_irq done");
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_mux();
      t_tc();
      t_isa();
      t_irq();
      results();
   end
endmodule
`default_nettype wire
